// ===== logic/t1pm_defs.svh
`ifndef T1PM_DEFS_SVH
`define T1PM_DEFS_SVH

// register indexes; byte address is four times the index
`define T1PM_ADDR_W 10
`define T1PM_IDX_INDEX_PORT 8'h0E
`define T1PM_IDX_READ_PORT 8'h0F
`define T1PM_IDX_CONTROL 8'hC2
`define T1PM_IDX_EN_LOW 8'hC3
`define T1PM_IDX_EN_HIGH 8'hC4
`define T1PM_IDX_FLAG_LOW 8'hC5
`define T1PM_IDX_FLAG_HIGH 8'hC6
`define T1PM_IDX_FORMAT 8'hC7

// reset values
`define T1PM_RST_BYTE 8'h00

// control register bits
`define T1PM_CTL_MANUAL 0
`define T1PM_CTL_AUTO 1

// format register fields
`define T1PM_FMT_LSB 0
`define T1PM_FMT_MSB 1
`define T1PM_FMT_B8ZS 2
`define T1PM_FMT_J1 3

// low flag / enable register bits
`define T1PM_BIT_CRC 0
`define T1PM_BIT_DDS 1
`define T1PM_BIT_POS 2
`define T1PM_BIT_SYNC 3
`define T1PM_BIT_PATTERN 4
// high flag / enable register bits
`define T1PM_BIT_LINE 0
`define T1PM_BIT_FRAME 1

// indirect snapshot indexes
`define T1PM_ID_CRC_LO 4'h0
`define T1PM_ID_CRC_HI 4'h1
`define T1PM_ID_FRAME_LO 4'h2
`define T1PM_ID_FRAME_HI 4'h3
`define T1PM_ID_POS 4'h4
`define T1PM_ID_SYNC 4'h5
`define T1PM_ID_PATTERN_LO 4'h6
`define T1PM_ID_PATTERN_HI 4'h7
`define T1PM_ID_LINE_LO 4'h8
`define T1PM_ID_LINE_HI 4'h9
`define T1PM_ID_DDS_LO 4'hA
`define T1PM_ID_DDS_HI 4'hB

// timing
`define T1PM_SEC_NS 1000000000
`define T1PM_CLK_NS 50

`endif

// ===== logic/t1pm_pkg.sv
package t1pm_pkg;

    // framing format, as held in the format register
    typedef enum logic [1:0]
    {
        fmt_sf = 2'h0,
        fmt_esf = 2'h1,
        fmt_dm = 2'h2,
        fmt_slc96 = 2'h3
    } t1pm_format_t;

    // one-cycle event strobes from decoder, framer and pattern checker
    typedef struct packed
    {
        logic bipolar_viol;
        logic code_viol;
        logic f_bit_err;
        logic fa_bit_err;
        logic crc6_err;
        logic dds_err;
        logic pos_change;
        logic sync_loss;
        logic pattern_err;
    } t1pm_events_t;

endpackage : t1pm_pkg

// ===== logic/t1pm_counter.sv
`timescale 1ns/100ps
`include "t1pm_defs.svh"

// wrapping event counter with clear and one-cycle overflow strobe
module t1pm_counter #(
    parameter int W = 16
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic inc, // count one event
    input wire logic clr, // start a new interval
    output logic [W-1:0] count_ff, // running count
    output logic ovf_ff // one-cycle overflow strobe
);

    // an event on the clearing cycle seeds the new interval with one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_ff <= '0;
        else if (clr)
            count_ff <= inc ? W'(1) : '0;
        else if (inc)
            count_ff <= count_ff + W'(1);
    end

    // overflow is the wrap from all ones; a clear hides it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovf_ff <= 1'b0;
        else
            ovf_ff <= inc && !clr && (count_ff == {W{1'b1}});
    end

endmodule : t1pm_counter

// ===== logic/t1pm_top.sv
`timescale 1ns/100ps
`include "t1pm_defs.svh"

module t1pm_top #(
    parameter int unsigned ONE_SEC_CYCLES = `T1PM_SEC_NS / `T1PM_CLK_NS
) (
    input wire logic pclk, // system clock, 20 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [`T1PM_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire t1pm_pkg::t1pm_events_t events, // event strobes, same clock
    output logic irq // level interrupt, active high
);

    localparam int PW = $clog2(ONE_SEC_CYCLES);

    logic [3:0] index_ff;
    logic [7:0] ctl_ff;
    logic [7:0] en_lo_ff;
    logic [7:0] en_hi_ff;
    logic [7:0] flag_lo_ff;
    logic [7:0] flag_hi_ff;
    logic [7:0] fmt_ff;
    logic manual_prev_ff;
    logic [PW-1:0] presc_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic [15:0] snap_line_ff;
    logic [11:0] snap_frame_ff;
    logic [9:0] snap_crc_ff;
    logic [9:0] snap_dds_ff;
    logic [2:0] snap_pos_ff;
    logic [4:0] snap_sync_ff;
    logic [15:0] snap_pattern_ff;
    logic [15:0] line_cnt;
    logic [11:0] frame_cnt;
    logic [9:0] crc_cnt;
    logic [9:0] dds_cnt;
    logic [2:0] pos_cnt;
    logic [4:0] sync_cnt;
    logic [15:0] pattern_cnt;
    logic line_ovf, frame_ovf, crc_ovf, dds_ovf, pos_ovf, sync_ovf, pattern_ovf;
    logic line_ev, frame_ev, crc_ev, dds_ev, pos_ev, sync_ev, pattern_ev;
    logic [7:0] nxt_flag_lo;
    logic [7:0] nxt_flag_hi;
    logic [7:0] set_lo;
    logic [7:0] set_hi;
    logic [7:0] reg_idx;
    logic setup, wr, tick, manual_edge, snap_now, fmt_ok;
    t1pm_pkg::t1pm_format_t fmt;

    // indexed byte of the snapshot bank; unused indexes read zero
    function automatic logic [7:0] snap_byte(input logic [3:0] id);
        logic [7:0] b;
        b = 8'h00;
        unique case (id)
            `T1PM_ID_CRC_LO: b = snap_crc_ff[7:0];
            `T1PM_ID_CRC_HI: b = {6'h00, snap_crc_ff[9:8]};
            `T1PM_ID_FRAME_LO: b = snap_frame_ff[7:0];
            `T1PM_ID_FRAME_HI: b = {4'h0, snap_frame_ff[11:8]};
            `T1PM_ID_POS: b = {5'h00, snap_pos_ff};
            `T1PM_ID_SYNC: b = {3'h0, snap_sync_ff};
            `T1PM_ID_PATTERN_LO: b = snap_pattern_ff[7:0];
            `T1PM_ID_PATTERN_HI: b = snap_pattern_ff[15:8];
            `T1PM_ID_LINE_LO: b = snap_line_ff[7:0];
            `T1PM_ID_LINE_HI: b = snap_line_ff[15:8];
            `T1PM_ID_DDS_LO: b = snap_dds_ff[7:0];
            `T1PM_ID_DDS_HI: b = {6'h00, snap_dds_ff[9:8]};
            default: b = 8'h00;
        endcase
        return b;
    endfunction : snap_byte

    // true when the register index is mapped
    function automatic logic reg_mapped(input logic [7:0] idx);
        return (idx == `T1PM_IDX_INDEX_PORT) || (idx == `T1PM_IDX_READ_PORT)
            || ((idx >= `T1PM_IDX_CONTROL) && (idx <= `T1PM_IDX_FORMAT));
    endfunction : reg_mapped

    // apb decode; writes land on the access edge, reads are staged at setup
    assign reg_idx = paddr[`T1PM_ADDR_W-1:2];
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && reg_mapped(reg_idx);
    assign pready = psel && penable;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff && psel && penable;

    // read data captured in setup so the access phase shows a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (setup)
        begin
            pslverr_ff <= !reg_mapped(reg_idx);
            unique case (reg_idx)
                `T1PM_IDX_INDEX_PORT: prdata_ff <= {28'h0000000, index_ff};
                `T1PM_IDX_READ_PORT: prdata_ff <= {24'h000000, snap_byte(index_ff)};
                `T1PM_IDX_CONTROL: prdata_ff <= {24'h000000, ctl_ff};
                `T1PM_IDX_EN_LOW: prdata_ff <= {24'h000000, en_lo_ff};
                `T1PM_IDX_EN_HIGH: prdata_ff <= {24'h000000, en_hi_ff};
                `T1PM_IDX_FLAG_LOW: prdata_ff <= {24'h000000, flag_lo_ff};
                `T1PM_IDX_FLAG_HIGH: prdata_ff <= {24'h000000, flag_hi_ff};
                `T1PM_IDX_FORMAT: prdata_ff <= {24'h000000, fmt_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // software-written configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            index_ff <= 4'h0;
            ctl_ff <= `T1PM_RST_BYTE;
            en_lo_ff <= `T1PM_RST_BYTE;
            en_hi_ff <= `T1PM_RST_BYTE;
            fmt_ff <= `T1PM_RST_BYTE;
        end
        else if (wr)
        begin
            unique case (reg_idx)
                `T1PM_IDX_INDEX_PORT: index_ff <= pwdata[3:0];
                `T1PM_IDX_CONTROL: ctl_ff <= {6'h00, pwdata[1:0]};
                `T1PM_IDX_EN_LOW: en_lo_ff <= {3'h0, pwdata[4:0]};
                `T1PM_IDX_EN_HIGH: en_hi_ff <= {6'h00, pwdata[1:0]};
                `T1PM_IDX_FORMAT: fmt_ff <= {4'h0, pwdata[3:0]};
                default: ;
            endcase
        end
    end

    // one-second prescaler runs free so the interval is steady
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc_ff <= '0;
        else if (tick)
            presc_ff <= '0;
        else
            presc_ff <= presc_ff + PW'(1);
    end
    assign tick = (presc_ff == PW'(ONE_SEC_CYCLES - 1));

    // manual trigger edge against the stored previous bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            manual_prev_ff <= 1'b0;
        else
            manual_prev_ff <= ctl_ff[`T1PM_CTL_MANUAL];
    end
    assign manual_edge = ctl_ff[`T1PM_CTL_MANUAL] && !manual_prev_ff;
    assign snap_now = manual_edge || (tick && ctl_ff[`T1PM_CTL_AUTO]);

    // event routing by format; DM and SLC-96 do not exist in J1
    assign fmt = t1pm_pkg::t1pm_format_t'(fmt_ff[`T1PM_FMT_MSB:`T1PM_FMT_LSB]);
    assign fmt_ok = !(fmt_ff[`T1PM_FMT_J1] && ((fmt == t1pm_pkg::fmt_dm)
        || (fmt == t1pm_pkg::fmt_slc96)));
    assign line_ev = fmt_ff[`T1PM_FMT_B8ZS] ? events.code_viol : events.bipolar_viol;
    assign frame_ev = fmt_ok && ((fmt == t1pm_pkg::fmt_esf) ? events.fa_bit_err
        : events.f_bit_err);
    assign crc_ev = (fmt == t1pm_pkg::fmt_esf) && events.crc6_err;
    assign dds_ev = fmt_ok && (fmt == t1pm_pkg::fmt_dm) && events.dds_err;
    assign pos_ev = fmt_ok && events.pos_change;
    assign sync_ev = fmt_ok && events.sync_loss;
    assign pattern_ev = events.pattern_err;

    // counters; snap_now clears them all at once
    t1pm_counter #(.W(16)) u_line (.pclk(pclk), .presetn(presetn), .inc(line_ev),
        .clr(snap_now), .count_ff(line_cnt), .ovf_ff(line_ovf));
    t1pm_counter #(.W(12)) u_frame (.pclk(pclk), .presetn(presetn), .inc(frame_ev),
        .clr(snap_now), .count_ff(frame_cnt), .ovf_ff(frame_ovf));
    t1pm_counter #(.W(10)) u_crc (.pclk(pclk), .presetn(presetn), .inc(crc_ev),
        .clr(snap_now), .count_ff(crc_cnt), .ovf_ff(crc_ovf));
    t1pm_counter #(.W(10)) u_dds (.pclk(pclk), .presetn(presetn), .inc(dds_ev),
        .clr(snap_now), .count_ff(dds_cnt), .ovf_ff(dds_ovf));
    t1pm_counter #(.W(3)) u_pos (.pclk(pclk), .presetn(presetn), .inc(pos_ev),
        .clr(snap_now), .count_ff(pos_cnt), .ovf_ff(pos_ovf));
    t1pm_counter #(.W(5)) u_sync (.pclk(pclk), .presetn(presetn), .inc(sync_ev),
        .clr(snap_now), .count_ff(sync_cnt), .ovf_ff(sync_ovf));
    t1pm_counter #(.W(16)) u_pattern (.pclk(pclk), .presetn(presetn), .inc(pattern_ev),
        .clr(snap_now), .count_ff(pattern_cnt), .ovf_ff(pattern_ovf));

    // snapshot bank takes the count before the same-edge clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            snap_line_ff <= 16'h0000;
            snap_frame_ff <= 12'h000;
            snap_crc_ff <= 10'h000;
            snap_dds_ff <= 10'h000;
            snap_pos_ff <= 3'h0;
            snap_sync_ff <= 5'h00;
            snap_pattern_ff <= 16'h0000;
        end
        else if (snap_now)
        begin
            snap_line_ff <= line_cnt;
            snap_frame_ff <= frame_cnt;
            snap_crc_ff <= crc_cnt;
            snap_dds_ff <= dds_cnt;
            snap_pos_ff <= pos_cnt;
            snap_sync_ff <= sync_cnt;
            snap_pattern_ff <= pattern_cnt;
        end
    end

    // sticky flags, write one to clear; a set in the same cycle wins
    always_comb
    begin
        set_lo = 8'h00;
        set_hi = 8'h00;
        set_lo[`T1PM_BIT_CRC] = crc_ovf;
        set_lo[`T1PM_BIT_DDS] = dds_ovf;
        set_lo[`T1PM_BIT_POS] = pos_ovf;
        set_lo[`T1PM_BIT_SYNC] = sync_ovf;
        set_lo[`T1PM_BIT_PATTERN] = pattern_ovf;
        set_hi[`T1PM_BIT_LINE] = line_ovf;
        set_hi[`T1PM_BIT_FRAME] = frame_ovf;
        nxt_flag_lo = flag_lo_ff;
        nxt_flag_hi = flag_hi_ff;
        if (wr && (reg_idx == `T1PM_IDX_FLAG_LOW))
            nxt_flag_lo = flag_lo_ff & ~pwdata[7:0];
        if (wr && (reg_idx == `T1PM_IDX_FLAG_HIGH))
            nxt_flag_hi = flag_hi_ff & ~pwdata[7:0];
        nxt_flag_lo = nxt_flag_lo | set_lo;
        nxt_flag_hi = nxt_flag_hi | set_hi;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_lo_ff <= `T1PM_RST_BYTE;
            flag_hi_ff <= `T1PM_RST_BYTE;
        end
        else
        begin
            flag_lo_ff <= nxt_flag_lo;
            flag_hi_ff <= nxt_flag_hi;
        end
    end

    // level interrupt, masked per flag
    assign irq = |(flag_lo_ff & en_lo_ff) || |(flag_hi_ff & en_hi_ff);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_manual_write;
        wr && (reg_idx == `T1PM_IDX_CONTROL) && pwdata[`T1PM_CTL_MANUAL]
            && !ctl_ff[`T1PM_CTL_MANUAL];
    endsequence

    sequence s_data_read_line;
        setup && !pwrite && (reg_idx == `T1PM_IDX_READ_PORT)
            && (index_ff == `T1PM_ID_LINE_LO);
    endsequence

    // every auto tick copies the counts, whether or not an event is present
    a_auto_snap_fire: assert property (
        (tick && ctl_ff[`T1PM_CTL_AUTO]) |=> (snap_line_ff == $past(line_cnt))
            && (snap_sync_ff == $past(sync_cnt))
    ) else $error("auto snapshot missed");

    a_manual_snap_edge: assert property (
        s_manual_write |=> snap_now ##1 (line_cnt == 16'h0000 || line_cnt == 16'h0001)
    ) else $error("manual trigger did not snapshot");

    a_clear_after_snap: assert property (
        (snap_now && !frame_ev) |=> (frame_cnt == 12'h000)
    ) else $error("counter not cleared by snapshot");

    a_event_not_lost: assert property (
        (snap_now && pattern_ev) |=> (pattern_cnt == 16'h0001)
    ) else $error("event lost at snapshot");

    a_overflow_flag_set: assert property (
        (line_ev && !snap_now && line_cnt == 16'hFFFF) |=> ##1 flag_hi_ff[`T1PM_BIT_LINE]
    ) else $error("overflow flag not set");

    // the short position counter is one a test can actually wrap
    a_pos_overflow_flag: assert property (
        (pos_ev && !snap_now && pos_cnt == 3'h7) |=> ##1 flag_lo_ff[`T1PM_BIT_POS]
    ) else $error("position overflow flag not set");

    a_irq_masked: assert property (
        (en_lo_ff == 8'h00 && en_hi_ff == 8'h00) |-> !irq
    ) else $error("interrupt with all enables low");

    a_read_line_byte: assert property (
        s_data_read_line |=> (prdata[7:0] == snap_line_ff[7:0]) && (prdata[31:8] == 24'h000000)
    ) else $error("indirect read returned wrong byte");

    a_crc_esf_only: assert property (
        (fmt != t1pm_pkg::fmt_esf && !snap_now) |=> $stable(crc_cnt)
    ) else $error("crc counter moved outside esf");

    a_dds_dm_only: assert property (
        ((fmt != t1pm_pkg::fmt_dm || fmt_ff[`T1PM_FMT_J1]) && !snap_now) |=> $stable(dds_cnt)
    ) else $error("dds counter moved outside t1 dm");

    a_flag_sticky: assert property (
        (flag_lo_ff[`T1PM_BIT_POS] && !(wr && reg_idx == `T1PM_IDX_FLAG_LOW))
            |=> flag_lo_ff[`T1PM_BIT_POS]
    ) else $error("flag dropped without clear");

    a_flag_clear_other: assert property (
        (wr && reg_idx == `T1PM_IDX_FLAG_LOW && set_hi == 8'h00) |=> $stable(flag_hi_ff)
    ) else $error("clearing low flags moved high flags");

    a_tick_period: assert property (
        tick |=> !tick
    ) else $error("prescaler tick too frequent");

endmodule : t1pm_top

// ===== tb/t1pm_event_src.sv
`timescale 1ns/100ps

// far-side strobe source: one count per cycle high, all on pclk
module t1pm_event_src (
    input wire logic pclk, // system clock
    output t1pm_pkg::t1pm_events_t events // event strobes
);
    initial events = '0;

    // strobes change just after an edge; a spare edge at the end keeps
    // back-to-back calls from assigning events twice in one time step
    task automatic pulse(input logic [8:0] mask, input int n);
        for (int i = 0; i < n; i++)
        begin
            events <= mask;
            @(posedge pclk);
        end
        events <= '0;
        @(posedge pclk);
    endtask : pulse
endmodule : t1pm_event_src

// ===== tb/t1pm_top_tb_top.sv
`timescale 1ns/100ps
`include "t1pm_defs.svh"

module t1pm_top_tb_top;
    localparam int unsigned SEC = 64; // shortened one-second count
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [`T1PM_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    t1pm_pkg::t1pm_events_t events;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int c[9];
    logic [7:0] eb[12];
    logic [7:0] rst_idx[7] = '{8'h0E, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
    logic [33:0] exp_q[$];
    logic [31:0] got;
    logic [3:0] fv;
    logic bad;
    logic esf;
    logic dm;

    t1pm_top #(.ONE_SEC_CYCLES(SEC)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events), .irq(irq)
    );

    t1pm_event_src u_src (
        .pclk(pclk),
        .events(events)
    );

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got_v);
        tests_run++;
        if (got_v !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got_v);
        end
    endtask : check

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // hang guard, far above the fewer than two thousand cycles the run needs
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    // read monitor: oldest note is matched to each completed read
    always @(posedge pclk)
    begin
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
        begin
            if (exp_q[0][33])
            begin
                check("prdata", exp_q[0][31:0], prdata);
                check("pslverr", {31'h0, exp_q[0][32]}, {31'h0, pslverr});
            end
            void'(exp_q.pop_front());
        end
    end

    // one apb transfer; waits an edge first so signals never change twice per step
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait-state budget here; only the hang guard ends a stuck access
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, idx, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic err = 1'b0);
        logic [31:0] x;
        exp_q.push_back({1'b1, err, e});
        apb(1'b0, idx, 32'h0, x);
    endtask : rd

    task automatic set_exp(input int crc, frm, pos, syn, pat, lin, dds);
        eb = '{crc[7:0], crc[15:8], frm[7:0], frm[15:8], pos[7:0], syn[7:0],
            pat[7:0], pat[15:8], lin[7:0], lin[15:8], dds[7:0], dds[15:8]};
    endtask : set_exp

    // manual trigger needs a stored zero before the one
    task automatic snap;
        wr(`T1PM_IDX_CONTROL, 32'h0);
        wr(`T1PM_IDX_CONTROL, 32'h1 << `T1PM_CTL_MANUAL);
    endtask : snap

    task automatic chk_snap;
        for (int i = 0; i < 12; i++)
        begin
            wr(`T1PM_IDX_INDEX_PORT, 32'(i));
            rd(`T1PM_IDX_READ_PORT, {24'h0, eb[i]});
        end
        rd(`T1PM_IDX_INDEX_PORT, 32'hB);
    endtask : chk_snap

    task automatic chk_irq(input logic e);
        @(negedge pclk);
        check("irq", {31'h0, e}, {31'h0, irq});
    endtask : chk_irq

    initial
    begin
        void'($urandom(17595));
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then an unmapped index
        foreach (rst_idx[k])
            rd(rst_idx[k], 32'h0);
        rd(8'h10, 32'h0, 1'b1);
        $display("test reset_and_map done");
        // every format, both line codes, and the two invalid J1 formats
        for (int fm = 0; fm < 10; fm++)
        begin
            fv = (fm < 8) ? 4'(fm) : ((fm == 8) ? 4'hA : 4'hB);
            wr(`T1PM_IDX_FORMAT, {28'h0, fv});
            for (int i = 0; i < 9; i++)
            begin
                c[i] = $urandom_range(3, 1);
                u_src.pulse(9'(1) << i, c[i]);
            end
            bad = fv[3] && fv[1];
            esf = (fv[1:0] == 2'h1);
            dm = (fv[1:0] == 2'h2) && !bad;
            set_exp(esf ? c[4] : 0, bad ? 0 : (esf ? c[5] : c[6]), bad ? 0 : c[2],
                bad ? 0 : c[1], c[0], fv[2] ? c[7] : c[8], dm ? c[3] : 0);
            snap();
            chk_snap();
        end
        $display("test formats done");
        // event on the snapshot edge lands in the fresh interval
        wr(`T1PM_IDX_CONTROL, 32'h0);
        wr(`T1PM_IDX_CONTROL, 32'h1);
        u_src.pulse(9'h001, 1);
        set_exp(0, 0, 0, 0, 0, 0, 0);
        chk_snap();
        snap();
        set_exp(0, 0, 0, 0, 1, 0, 0);
        chk_snap();
        $display("test snapshot_edge done");
        // position counter wraps after eight, flag sticks, irq follows enable
        wr(`T1PM_IDX_FORMAT, 32'h0);
        u_src.pulse(9'h004, 8);
        chk_irq(1'b0);
        rd(`T1PM_IDX_FLAG_LOW, 32'h1 << `T1PM_BIT_POS);
        rd(`T1PM_IDX_FLAG_HIGH, 32'h0);
        wr(`T1PM_IDX_EN_LOW, 32'h1 << `T1PM_BIT_POS);
        chk_irq(1'b1);
        rd(`T1PM_IDX_FLAG_LOW, 32'h1 << `T1PM_BIT_POS);
        wr(`T1PM_IDX_FLAG_LOW, 32'h1 << `T1PM_BIT_POS);
        chk_irq(1'b0);
        rd(`T1PM_IDX_FLAG_LOW, 32'h0);
        rd(`T1PM_IDX_EN_LOW, 32'h1 << `T1PM_BIT_POS);
        $display("test overflow_irq done");
        // automatic snapshot: poll sync byte until the tick copies it
        wr(`T1PM_IDX_CONTROL, 32'h1 << `T1PM_CTL_AUTO);
        wr(`T1PM_IDX_INDEX_PORT, 32'h5);
        u_src.pulse(9'h002, 1);
        got = 32'h0;
        for (int k = 0; k < 100 && got !== 32'h1; k++)
        begin
            exp_q.push_back(34'h0);
            apb(1'b0, `T1PM_IDX_READ_PORT, 32'h0, got);
        end
        rd(`T1PM_IDX_READ_PORT, 32'h1);
        repeat (SEC + 4) @(posedge pclk);
        rd(`T1PM_IDX_READ_PORT, 32'h0);
        wr(`T1PM_IDX_CONTROL, 32'h0);
        $display("test auto_snapshot done");
        end_sim();
    end
endmodule : t1pm_top_tb_top
